// [src/wdrc_map.svh]
// Purpose: offsets, field positions, reset values and timing counts of the watchdog block
// Assumes: byte-wide registers on a plain strobe port, one register per index
// Notes:   definitions only
`ifndef WDRC_MAP_SVH
`define WDRC_MAP_SVH

// register indexes
`define WDRC_ADDR_W        4
`define WDRC_OFF_CAUSE     4'h0
`define WDRC_OFF_CTRL      4'h1

// reset_cause_status fields
`define WDRC_CAUSE_PWR     0
`define WDRC_CAUSE_PIN     1
`define WDRC_CAUSE_LOW     2
`define WDRC_CAUSE_DOG     3

// dog_control_status fields
`define WDRC_CTL_TSEL0     0
`define WDRC_CTL_TSEL2     2
`define WDRC_CTL_RE        3
`define WDRC_CTL_CE        4
`define WDRC_CTL_TSEL3     5
`define WDRC_CTL_IE        6
`define WDRC_CTL_FLAG      7

// reset value and largest select code
`define WDRC_TSEL_RST      4'h0
`define WDRC_TSEL_MAX      4'h9

// timing
`define WDRC_CLK_HZ        40000000
`define WDRC_OSC_HZ        128000
`define WDRC_TOUT_MIN_MS   16
`define WDRC_TOUT_MAX_MS   8000
`define WDRC_BASE_TICKS    ((`WDRC_TOUT_MIN_MS * `WDRC_OSC_HZ) / 1000)
`define WDRC_WIN_CYCLES    3'h4

`endif

// [src/wdrc_pkg.sv]
// Purpose: shared types of the watchdog block
// Assumes: constants live in wdrc_map.svh
// Notes:   none
`default_nettype none

package wdrc_pkg;

	typedef enum logic [1:0] {
		WDRC_STOPPED,
		WDRC_IRQ_ONLY,
		WDRC_RST_ONLY,
		WDRC_IRQ_THEN_RST
	} wdrc_mode_t;

	// stored control settings
	typedef struct packed {
		logic       ie;
		logic       re;
		logic [3:0] tsel;
	} wdrc_ctl_t;

	// reset cause flags, msb first
	typedef struct packed {
		logic dog;
		logic low;
		logic pin;
		logic pwr;
	} wdrc_cause_t;

endpackage

`default_nettype wire

// [src/wdrc_sync.sv]
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are slow levels or a slow clock
// Notes:   first stage feeds only the second
`default_nettype none

module wdrc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// levels
	input  wire logic [WIDTH-1:0] d_i,
	output var  logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule

`default_nettype wire

// [src/wdrc_top.sv]
// Purpose: watchdog with timed change protection and reset cause flags
// Assumes: rstn_i is the power-on reset; oscillator and reset sources arrive as pins
// Notes:   registers on a plain strobe port, read data one cycle after the strobe
//
// The address map and strobed register access were left to the implementer.
`include "wdrc_map.svh"
`default_nettype none

// Operation
// RULE_01: dog flag set on dog reset
// RULE_02: low-supply flag set on brown-out reset
// RULE_03: pin flag set on external reset
// RULE_04: power-up flag cleared only by software
// RULE_05: software reads then clears cause flags early
// RULE_06: counter advances on 128 kHz oscillator
// RULE_07: expiry gives interrupt or reset per mode
// RULE_08: restart instruction clears counter to zero
// RULE_09: interrupt mode raises interrupt, no reset
// RULE_10: reset mode expiry resets the system
// RULE_11: combined mode: interrupt, then reset mode
// RULE_12: fuse forces reset mode, interrupt off
// RULE_13: open window writes change and reset enable
// RULE_14: guarded changes only within four cycles
// RULE_15: time-out selectable from 16ms to 8s
// RULE_16: watchdog stays enabled after dog reset
// RULE_17: init software clears dog flag, reset enable
// RULE_18: reset enable forced while dog flag set
// RULE_19: change enable self-clears after four cycles
// RULE_20: time-out flag set, cleared by ack/one
// RULE_21: select codes give 2K to 1024K ticks
// RULE_22: guarded bits unchanged outside open window
module wdrc_top #(
	parameter int BASE_TICKS = `WDRC_BASE_TICKS,
	parameter int CNT_W      = 21
) (
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rstn_i,
	// register port
	input  wire logic [`WDRC_ADDR_W-1:0] addr_i,
	input  wire logic [7:0]              wdata_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output var  logic [7:0]              rdata_o,
	// core side
	input  wire logic                    kick_i,
	input  wire logic                    irq_ack_i,
	output var  logic                    irq_o,
	output var  logic                    dog_reset_o,
	// pins
	input  wire logic                    osc_i,
	input  wire logic                    low_supply_rst_i,
	input  wire logic                    pin_rst_i,
	input  wire logic                    always_on_fuse_i
);

	logic [3:0]           sync_w;
	logic                 osc_s;
	logic                 low_s;
	logic                 pin_s;
	logic                 fuse_s;
	logic                 osc_prev_q;
	logic                 tick;
	logic                 sys_rst;
	logic                 wr_cause;
	logic                 wr_ctrl;
	logic                 open_wr;
	logic                 win_open;
	logic [2:0]           win_q;
	wdrc_pkg::wdrc_ctl_t  ctl_q;
	wdrc_pkg::wdrc_cause_t cause_q;
	logic                 flag_q;
	logic                 re_eff;
	wdrc_pkg::wdrc_mode_t mode;
	logic [CNT_W-1:0]     cnt_q;
	logic [CNT_W-1:0]     limit;
	logic                 expire;
	logic                 irq_set;
	logic                 rst_fire;
	logic [7:0]           rd_mux;

	wdrc_sync #(
		.WIDTH (4)
	) u_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    ({osc_i, low_supply_rst_i, pin_rst_i, always_on_fuse_i}),
		.q_o    (sync_w)
	);

	assign osc_s  = sync_w[3];
	assign low_s  = sync_w[2];
	assign pin_s  = sync_w[1];
	assign fuse_s = sync_w[0];

	// RULE_06 oscillator edge tick
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			osc_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_s;
		end
	end
	assign tick = osc_s & ~osc_prev_q;

	// any non power-on system reset returns the settings to their defaults
	assign sys_rst  = dog_reset_o | low_s | pin_s;
	assign wr_cause = wr_i && (addr_i == `WDRC_OFF_CAUSE);
	assign wr_ctrl  = wr_i && (addr_i == `WDRC_OFF_CTRL);

	// RULE_13 opening write
	assign open_wr  = wr_ctrl && wdata_i[`WDRC_CTL_CE] && wdata_i[`WDRC_CTL_RE];
	assign win_open = (win_q != 3'h0);

	// RULE_19 change enable countdown
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			win_q <= 3'h0;
		end else if (sys_rst) begin
			win_q <= 3'h0;
		end else if (open_wr) begin
			win_q <= `WDRC_WIN_CYCLES;
		end else if (wr_ctrl && win_open) begin
			// one write uses the window up
			win_q <= 3'h0;
		end else if (win_open) begin
			win_q <= win_q - 3'h1;
		end
	end

	// RULE_14 guarded change in window
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl_q.re   <= 1'b0;
			ctl_q.tsel <= `WDRC_TSEL_RST;
		end else if (sys_rst) begin
			ctl_q.re   <= 1'b0;
			ctl_q.tsel <= `WDRC_TSEL_RST;
		end else if (open_wr) begin
			ctl_q.re <= 1'b1;
		end else if (wr_ctrl && win_open && !wdata_i[`WDRC_CTL_CE]) begin
			// RULE_18 no clear while dog flag set
			ctl_q.re   <= wdata_i[`WDRC_CTL_RE] | cause_q.dog;
			ctl_q.tsel <= {wdata_i[`WDRC_CTL_TSEL3], wdata_i[`WDRC_CTL_TSEL2:`WDRC_CTL_TSEL0]};
		end else if (wr_ctrl && wdata_i[`WDRC_CTL_RE]) begin
			// RULE_22 only setting passes unguarded
			ctl_q.re <= 1'b1;
		end
	end

	// RULE_12 fuse holds interrupt enable low
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl_q.ie <= 1'b0;
		end else if (sys_rst || fuse_s) begin
			ctl_q.ie <= 1'b0;
		end else if (irq_ack_i && mode == wdrc_pkg::WDRC_IRQ_THEN_RST) begin
			// RULE_11 vector entry returns to reset mode
			ctl_q.ie <= 1'b0;
		end else if (wr_ctrl) begin
			ctl_q.ie <= wdata_i[`WDRC_CTL_IE];
		end
	end

	// RULE_12 RULE_16 RULE_18 effective reset enable
	assign re_eff = ctl_q.re | cause_q.dog | fuse_s;

	always_comb begin
		case ({re_eff, ctl_q.ie})
			2'b01:   mode = wdrc_pkg::WDRC_IRQ_ONLY;
			2'b10:   mode = wdrc_pkg::WDRC_RST_ONLY;
			2'b11:   mode = wdrc_pkg::WDRC_IRQ_THEN_RST;
			default: mode = wdrc_pkg::WDRC_STOPPED;
		endcase
	end

	// RULE_15 RULE_21 time-out in ticks, reserved codes take the longest
	always_comb begin
		limit = CNT_W'(BASE_TICKS);
		if (ctl_q.tsel > `WDRC_TSEL_MAX) begin
			limit = limit << `WDRC_TSEL_MAX;
		end else begin
			limit = limit << ctl_q.tsel;
		end
	end

	// RULE_07 expiry on the tick that completes the period
	assign expire   = tick && (mode != wdrc_pkg::WDRC_STOPPED) && (cnt_q >= limit - CNT_W'(1));
	// RULE_09 RULE_11 first expiry interrupts
	assign irq_set  = expire && ((mode == wdrc_pkg::WDRC_IRQ_ONLY) ||
		(mode == wdrc_pkg::WDRC_IRQ_THEN_RST && !flag_q));
	// RULE_10 RULE_11 reset on expiry
	assign rst_fire = expire && ((mode == wdrc_pkg::WDRC_RST_ONLY) ||
		(mode == wdrc_pkg::WDRC_IRQ_THEN_RST && flag_q));

	// RULE_08 restart clears counter
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
		end else if (sys_rst || kick_i || expire || mode == wdrc_pkg::WDRC_STOPPED) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// RULE_20 time-out flag, set wins
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_q <= 1'b0;
		end else if (irq_set) begin
			flag_q <= 1'b1;
		end else if (sys_rst) begin
			flag_q <= 1'b0;
		end else if (irq_ack_i || (wr_ctrl && wdata_i[`WDRC_CTL_FLAG])) begin
			flag_q <= 1'b0;
		end
	end

	// RULE_10 one-cycle reset pulse
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dog_reset_o <= 1'b0;
		end else begin
			dog_reset_o <= rst_fire;
		end
	end

	// RULE_09 interrupt level also serves as wake request
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= flag_q & ctl_q.ie;
		end
	end

	// RULE_01 RULE_02 RULE_03 RULE_04 cause flags, set wins over write zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cause_q <= 4'h1;
		end else begin
			cause_q.dog <= dog_reset_o |
				(cause_q.dog & ~(wr_cause & ~wdata_i[`WDRC_CAUSE_DOG]));
			cause_q.low <= low_s |
				(cause_q.low & ~(wr_cause & ~wdata_i[`WDRC_CAUSE_LOW]));
			cause_q.pin <= pin_s |
				(cause_q.pin & ~(wr_cause & ~wdata_i[`WDRC_CAUSE_PIN]));
			cause_q.pwr <= cause_q.pwr & ~(wr_cause & ~wdata_i[`WDRC_CAUSE_PWR]);
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		case (addr_i)
			`WDRC_OFF_CAUSE: begin
				rd_mux[`WDRC_CAUSE_DOG:`WDRC_CAUSE_PWR] = cause_q;
			end
			`WDRC_OFF_CTRL: begin
				rd_mux[`WDRC_CTL_FLAG]                   = flag_q;
				rd_mux[`WDRC_CTL_IE]                     = ctl_q.ie;
				rd_mux[`WDRC_CTL_TSEL3]                  = ctl_q.tsel[3];
				rd_mux[`WDRC_CTL_CE]                     = win_open;
				rd_mux[`WDRC_CTL_RE]                     = re_eff;
				rd_mux[`WDRC_CTL_TSEL2:`WDRC_CTL_TSEL0]  = ctl_q.tsel[2:0];
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? rd_mux : 8'h00;
		end
	end

endmodule

`default_nettype wire

// [tb/wdrc_properties.sv]
// Purpose: port checks of the watchdog block
// Assumes: one clock domain, reset low
// Notes:   bound into wdrc_top
`default_nettype none
module wdrc_properties (
	// bus
	input wire logic       clk_i,
	input wire logic       rstn_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	// core and pins
	input wire logic       irq_o,
	input wire logic       dog_reset_o,
	input wire logic       low_supply_rst_i,
	input wire logic       pin_rst_i,
	input wire logic       always_on_fuse_i
);
	logic rdc;
	logic rdk;
	logic clr_q;
	assign rdc = rd_i && addr_i == 4'h0;
	assign rdk = rd_i && addr_i == 4'h1;
	// software has cleared the power-up flag
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) clr_q <= 1'b0;
		else if (wr_i && addr_i == 4'h0 && !wdata_i[0]) clr_q <= 1'b1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	AST_DOG_PULSE: assert property (dog_reset_o |=> !dog_reset_o)
		else $error("reset pulse too long");
	AST_DOG_FLAG: assert property (dog_reset_o ##1 !wr_i [*3] ##0 rdc |=> rdata_o[3])
		else $error("dog flag missing");
	AST_RE_HELD: assert property (dog_reset_o ##1 !wr_i [*5] ##0 rdk |=> rdata_o[3])
		else $error("reset enable dropped");
	AST_PWR_KEEP: assert property (rdc && !clr_q |=> rdata_o[0])
		else $error("power-up flag lost");
	AST_PIN_FLAG: assert property (pin_rst_i [*3] ##1 !wr_i [*2] ##0 rdc |=> rdata_o[1])
		else $error("pin flag missing");
	AST_LOW_FLAG: assert property (low_supply_rst_i [*3] ##1 !wr_i [*2] ##0 rdc |=> rdata_o[2])
		else $error("low supply flag missing");
	AST_FUSE_IRQ: assert property (always_on_fuse_i [*6] |-> !irq_o)
		else $error("interrupt under fuse");
	AST_FUSE_READ: assert property (always_on_fuse_i [*6] ##0 rdk |=> rdata_o[3] && !rdata_o[6])
		else $error("fuse bits wrong");
	AST_CE_CLOSE: assert property (wr_i && addr_i == 4'h1 && wdata_i[4:3] == 2'b11 ##1 !wr_i [*6] ##0 rdk |=> !rdata_o[4])
		else $error("window still open");
	cover property (dog_reset_o);
	cover property ($rose(irq_o));
	cover property (rdk ##1 rdata_o[4]);
endmodule
bind wdrc_top wdrc_properties u_props (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .irq_o, .dog_reset_o, .low_supply_rst_i, .pin_rst_i, .always_on_fuse_i);
`default_nettype wire

// [tb/wdrc_top_test.sv]
// Purpose: self-checking bench of the watchdog block
// Assumes: base count cut to 4 ticks, one tick every 8 clocks
// Notes:   select timing in a table, then the awkward cases
`default_nettype none
module wdrc_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       kick_i = 1'b0;
	logic       irq_ack_i = 1'b0;
	logic       low_supply_rst_i = 1'b0;
	logic       pin_rst_i = 1'b0;
	logic       always_on_fuse_i = 1'b0;
	logic [2:0] osc_cnt = 3'h0;
	logic       seen_rst = 1'b0;
	logic [7:0] rdata_o;
	logic       irq_o;
	logic       dog_reset_o;
	int         n_errors = 0;
	int         check_count = 0;
	int         rows [5][2] = '{'{0, 4}, '{1, 8}, '{3, 32}, '{9, 2048}, '{15, 2048}};
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) osc_cnt <= osc_cnt + 3'h1;
	always @(posedge clk_i) if (dog_reset_o) seen_rst <= 1'b1;
	wdrc_top #(.BASE_TICKS(4)) uut (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .kick_i, .irq_ack_i, .irq_o, .dog_reset_o, .osc_i(osc_cnt[2]),
		.low_supply_rst_i, .pin_rst_i, .always_on_fuse_i);
	task automatic close_out();
		if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		cmp({24'h0, rdata_o}, {24'h0, exp});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic kick();
		@(posedge clk_i);
		kick_i <= 1'b1;
		@(posedge clk_i);
		kick_i <= 1'b0;
	endtask
	task automatic ack();
		@(posedge clk_i);
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
	endtask
	task automatic wait_for(input logic on_irq, input int lim, output int cyc);
		for (cyc = 1; cyc <= lim; cyc++) begin
			@(negedge clk_i);
			if ((on_irq ? irq_o : dog_reset_o) === 1'b1) return;
		end
		n_errors++;
		close_out();
	endtask
	initial begin
		int n;
		int cyc;
		logic [3:0] sel;
		logic [7:0] cfg;
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		foreach (rows[i]) begin
			sel = 4'(rows[i][0]);
			n = rows[i][1];
			cfg = {2'b01, sel[3], 2'b00, sel[2:0]};
			wr(4'h1, 8'h18);
			wr(4'h1, cfg);
			kick();
			wait_for(1'b1, n * 8 + 40, cyc);
			cmp(32'(cyc >= n * 8 - 8 && cyc < n * 8 + 8), 32'h1);
			rd_chk(4'h1, {1'b1, cfg[6:0]});
			ack();
			kick();
			rd_chk(4'h1, cfg);
		end
		cmp({31'h0, seen_rst}, 32'h0);
		wr(4'h1, 8'h18);
		wr(4'h1, 8'h48);
		kick();
		wait_for(1'b1, 80, cyc);
		wait_for(1'b0, 80, cyc);
		repeat (2) @(posedge clk_i);
		rd_chk(4'h0, 8'h09);
		rd_chk(4'h1, 8'h08);
		kick();
		wr(4'h1, 8'h18);
		wr(4'h1, 8'h00);
		rd_chk(4'h1, 8'h08);
		wr(4'h0, 8'h00);
		kick();
		wr(4'h1, 8'h18);
		wr(4'h1, 8'h00);
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h1, 8'h00);
		wr(4'h1, 8'h08);
		wr(4'h1, 8'h18);
		rd_chk(4'h1, 8'h18);
		rd_chk(4'h1, 8'h18);
		rd_chk(4'h1, 8'h08);
		kick();
		wr(4'h1, 8'h05);
		rd_chk(4'h1, 8'h08);
		wr(4'h1, 8'h18);
		wr(4'h1, 8'h00);
		always_on_fuse_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		kick();
		wr(4'h1, 8'h40);
		rd_chk(4'h1, 8'h08);
		wait_for(1'b0, 80, cyc);
		@(posedge clk_i);
		always_on_fuse_i <= 1'b0;
		pin_rst_i <= 1'b1;
		low_supply_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		pin_rst_i <= 1'b0;
		low_supply_rst_i <= 1'b0;
		rd_chk(4'h0, 8'h0E);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd_chk(4'h0, 8'h01);
		rd_chk(4'h1, 8'h00);
		rd_chk(4'h2, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
